//--- ufc_frame_timing.sv
// Frame interval, frame remaining and frame number logic of a
// USB host controller, reached through a command-code register port.
// Assumes command, reset command and bus state come from logic on clk.
//
// How it works
// - A 14-bit interval field sets bit times between start-of-frame tokens.
// - Interval comes up at 11999 and returns there on controller reset command.
// - Each frame start loads the 15-bit largest-packet field into its counter.
// - A readable 14-bit remaining counter decrements once per bit time.
// - At zero the remaining counter reloads from the interval next bit time.
// - At zero the interval toggle is copied into the remaining toggle, bit 31.
// - Entering operational state reloads remaining; new interval used next frame.
// - Interval register is read with code 0d and written with code 8d.
// - Remaining register is read-only through code 0e; writes do nothing.
// - A 16-bit frame number counter is read-only through code 0f.
// - Frame number increments on every reload, also on operational entry.
// - Frame number wraps from its maximum back to zero.
// - Every frame number increment sets the start-of-frame flag.
`timescale 1ns/1ps

module ufc_frame_timing (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register command port
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [31:0] cmdWrData,
    output logic [31:0] rdData,
    output logic rdValid,
    // Controller state
    input wire logic controllerResetCmd,
    input wire logic operationalBusState,
    // Frame events and counters
    output logic startOfFrameFlag,
    output logic [14:0] largestPacketCount
);

    // Interval register fields
    logic [13:0] frameIntervalBits_reg;
    logic [14:0] fsLargestPacketBits_reg;
    logic intervalToggle_reg;

    // Remaining register and frame number
    logic [13:0] frameRemainingCount_reg;
    logic remainingToggle_reg;
    logic [15:0] frameCount_reg;

    // Bit-time pacing and state tracking
    logic [4:0] bitAcc_reg;
    logic bitTick_reg;
    logic operationalPrev_reg;

    // Decoded strobes and frame events
    logic intervalWrite;
    logic operationalEntry;
    logic frameEnd;
    logic frameReload;
    logic [5:0] accSum;

    // Command decode
    assign intervalWrite = cmdValid && (cmdCode == ufc_pkg::CMD_INTERVAL_WR);

    // Rising edge of the operational state
    assign operationalEntry = operationalBusState && !operationalPrev_reg;

    // Counter hit zero on a bit-time boundary while running
    assign frameEnd = operationalBusState && !operationalEntry && bitTick_reg
        && (frameRemainingCount_reg == 14'h0000);

    // Any reload starts a new frame
    assign frameReload = frameEnd || operationalEntry;

    // Fractional divider: 12 ticks in every 25 clocks
    // One spare bit, since accumulator plus step reaches 36
    assign accSum = {1'b0, bitAcc_reg} + {1'b0, ufc_pkg::ACC_STEP};

    // Bit-time enable; jitters by one clock but averages 12 MHz
    always_ff @(posedge clk) begin
        if (rst) begin
            bitAcc_reg <= 5'h00;
            bitTick_reg <= 1'b0;
        end else if (accSum >= {1'b0, ufc_pkg::ACC_WRAP}) begin
            bitAcc_reg <= 5'(accSum - {1'b0, ufc_pkg::ACC_WRAP});
            bitTick_reg <= 1'b1;
        end else begin
            bitAcc_reg <= accSum[4:0];
            bitTick_reg <= 1'b0;
        end
    end

    // Operational state history for entry detection
    always_ff @(posedge clk) begin
        if (rst) begin
            operationalPrev_reg <= 1'b0;
        end else begin
            operationalPrev_reg <= operationalBusState;
        end
    end

    // Interval field; reset command beats a same-cycle write
    always_ff @(posedge clk) begin
        if (rst) begin
            frameIntervalBits_reg <= ufc_pkg::FI_DEFAULT;
        end else if (controllerResetCmd) begin
            frameIntervalBits_reg <= ufc_pkg::FI_DEFAULT;
        end else if (intervalWrite) begin
            frameIntervalBits_reg <= cmdWrData[ufc_pkg::FI_LSB +: ufc_pkg::FI_W];
        end
    end

    // Largest-packet field and interval toggle, plain storage
    always_ff @(posedge clk) begin
        if (rst) begin
            fsLargestPacketBits_reg <= ufc_pkg::FSLP_RESET;
            intervalToggle_reg <= 1'b0;
        end else if (intervalWrite) begin
            fsLargestPacketBits_reg <= cmdWrData[ufc_pkg::FSLP_LSB +: ufc_pkg::FSLP_W];
            intervalToggle_reg <= cmdWrData[ufc_pkg::TOGGLE_BIT];
        end
    end

    // Remaining down counter; holds while not operational
    always_ff @(posedge clk) begin
        if (rst) begin
            frameRemainingCount_reg <= ufc_pkg::FR_RESET;
        end else if (frameReload) begin
            frameRemainingCount_reg <= frameIntervalBits_reg;
        end else if (operationalBusState && bitTick_reg) begin
            frameRemainingCount_reg <= frameRemainingCount_reg - 14'h0001;
        end
    end

    // Remaining toggle follows the interval toggle at each zero
    always_ff @(posedge clk) begin
        if (rst) begin
            remainingToggle_reg <= 1'b0;
        end else if (frameEnd) begin
            remainingToggle_reg <= intervalToggle_reg;
        end
    end

    // Frame number; natural 16-bit wrap
    always_ff @(posedge clk) begin
        if (rst) begin
            frameCount_reg <= ufc_pkg::FN_RESET;
        end else if (frameReload) begin
            frameCount_reg <= frameCount_reg + 16'h0001;
        end
    end

    // Frame start pulse and largest-packet counter load
    always_ff @(posedge clk) begin
        if (rst) begin
            startOfFrameFlag <= 1'b0;
            largestPacketCount <= ufc_pkg::FSLP_RESET;
        end else begin
            startOfFrameFlag <= frameReload;
            if (frameReload) begin
                largestPacketCount <= fsLargestPacketBits_reg;
            end
        end
    end

    // Read path; unknown codes and writes answer zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= 32'h0000_0000;
            rdValid <= 1'b0;
        end else begin
            rdValid <= cmdValid;
            rdData <= 32'h0000_0000;
            if (cmdValid) begin
                case (cmdCode)
                    ufc_pkg::CMD_INTERVAL_RD: begin
                        rdData <= {intervalToggle_reg, fsLargestPacketBits_reg,
                            2'b00, frameIntervalBits_reg};
                    end
                    ufc_pkg::CMD_REMAINING_RD: begin
                        rdData <= {remainingToggle_reg, 17'h00000,
                            frameRemainingCount_reg};
                    end
                    ufc_pkg::CMD_NUMBER_RD: begin
                        rdData <= {16'h0000, frameCount_reg};
                    end
                    default: begin
                        rdData <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Checks on the frame timing behaviour

    sequence s_frameEnd;
        frameEnd;
    endsequence

    sequence s_entry;
        operationalEntry;
    endsequence

    property p_reloadAtZero;
        @(posedge clk) disable iff (rst)
        s_frameEnd |=> frameRemainingCount_reg == $past(frameIntervalBits_reg);
    endproperty
    a_reloadAtZero: assert property (p_reloadAtZero)
        else $error("remaining not reloaded at zero");

    property p_decrement;
        @(posedge clk) disable iff (rst)
        operationalBusState && !frameReload && bitTick_reg
        |=> frameRemainingCount_reg == $past(frameRemainingCount_reg) - 14'h0001;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("remaining did not decrement");

    property p_holdIdle;
        @(posedge clk) disable iff (rst)
        !operationalBusState |=> $stable(frameRemainingCount_reg);
    endproperty
    a_holdIdle: assert property (p_holdIdle)
        else $error("remaining moved while idle");

    property p_toggleCopy;
        @(posedge clk) disable iff (rst)
        s_frameEnd |=> remainingToggle_reg == $past(intervalToggle_reg);
    endproperty
    a_toggleCopy: assert property (p_toggleCopy)
        else $error("remaining toggle not copied");

    property p_entryReload;
        @(posedge clk) disable iff (rst)
        s_entry |=> frameRemainingCount_reg == $past(frameIntervalBits_reg)
            ##0 startOfFrameFlag;
    endproperty
    a_entryReload: assert property (p_entryReload)
        else $error("entry did not reload remaining");

    property p_frameIncrement;
        @(posedge clk) disable iff (rst)
        frameReload |=> frameCount_reg == $past(frameCount_reg) + 16'h0001;
    endproperty
    a_frameIncrement: assert property (p_frameIncrement)
        else $error("frame number not incremented");

    property p_frameWrap;
        @(posedge clk) disable iff (rst)
        frameReload && frameCount_reg == 16'hffff |=> frameCount_reg == 16'h0000;
    endproperty
    a_frameWrap: assert property (p_frameWrap)
        else $error("frame number did not wrap");

    property p_sofFlag;
        @(posedge clk) disable iff (rst)
        $changed(frameCount_reg) |-> startOfFrameFlag;
    endproperty
    a_sofFlag: assert property (p_sofFlag)
        else $error("frame flag missing on increment");

    property p_largestLoad;
        @(posedge clk) disable iff (rst)
        frameReload |=> largestPacketCount == $past(fsLargestPacketBits_reg);
    endproperty
    a_largestLoad: assert property (p_largestLoad)
        else $error("largest packet counter not loaded");

    property p_resetCmd;
        @(posedge clk) disable iff (rst)
        controllerResetCmd |=> frameIntervalBits_reg == ufc_pkg::FI_DEFAULT;
    endproperty
    a_resetCmd: assert property (p_resetCmd)
        else $error("interval not back at default");

    property p_readRemaining;
        @(posedge clk) disable iff (rst)
        cmdValid && cmdCode == ufc_pkg::CMD_REMAINING_RD |=> rdValid
            && rdData == {$past(remainingToggle_reg), 17'h00000,
            $past(frameRemainingCount_reg)};
    endproperty
    a_readRemaining: assert property (p_readRemaining)
        else $error("remaining read wrong");

    property p_readNumber;
        @(posedge clk) disable iff (rst)
        cmdValid && cmdCode == ufc_pkg::CMD_NUMBER_RD
        |=> rdData == {16'h0000, $past(frameCount_reg)};
    endproperty
    a_readNumber: assert property (p_readNumber)
        else $error("frame number read wrong");

    property p_writeInterval;
        @(posedge clk) disable iff (rst)
        intervalWrite && !controllerResetCmd
        |=> frameIntervalBits_reg == $past(cmdWrData[13:0])
            && intervalToggle_reg == $past(cmdWrData[31]);
    endproperty
    a_writeInterval: assert property (p_writeInterval)
        else $error("interval write not stored");

endmodule // ufc_frame_timing

//--- ufc_pkg.sv
// Constants for the USB frame timing counters: register codes,
// field positions, reset values and bit-time pacing.
// Assumes a single 25 MHz clock and full-speed bit times.
package ufc_pkg;
    // Clock and full-speed bit rate, in MHz
    localparam int CLK_MHZ = 25;
    localparam int BIT_MHZ = 12;
    localparam logic [4:0] ACC_STEP = 5'(BIT_MHZ);
    localparam logic [4:0] ACC_WRAP = 5'(CLK_MHZ);

    // Command codes of the parallel register port
    localparam logic [7:0] CMD_INTERVAL_RD = 8'h0d;
    localparam logic [7:0] CMD_INTERVAL_WR = 8'h8d;
    localparam logic [7:0] CMD_REMAINING_RD = 8'h0e;
    localparam logic [7:0] CMD_NUMBER_RD = 8'h0f;

    // Field positions and widths
    localparam int TOGGLE_BIT = 31;
    localparam int FSLP_LSB = 16;
    localparam int FSLP_W = 15;
    localparam int FI_LSB = 0;
    localparam int FI_W = 14;
    localparam int FN_W = 16;

    // Reset values
    localparam logic [13:0] FI_DEFAULT = 14'h2edf;
    localparam logic [14:0] FSLP_RESET = 15'h0000;
    localparam logic [13:0] FR_RESET = 14'h0000;
    localparam logic [15:0] FN_RESET = 16'h0000;
endpackage

//--- ufc_testbench.sv
// Self-checking bench for the frame timing counters, driven on the command port.
// Assumes ufc_pkg and ufc_frame_timing are compiled first; one 25 MHz clock.
`timescale 1ns/1ps

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    logic [7:0] cmdCode = 8'h00;
    logic [31:0] cmdWrData = 32'h0;
    logic controllerResetCmd = 1'b0;
    logic operationalBusState = 1'b0;
    logic [31:0] rdData;
    logic rdValid;
    logic startOfFrameFlag;
    logic [14:0] largestPacketCount;
    int miscompares = 0;
    int nCompared = 0;
    int cycleCount = 0;
    int lastFlag = 0;
    int frames = 0;
    logic [15:0] lfsrState = 16'h0017;
    logic [31:0] ivWord;
    logic [31:0] rd;
    logic [31:0] held;
    logic [31:0] savedWord;
    logic [31:0] swCount = 32'h0;
    logic [7:0] badCodes [3] = '{8'h8e, 8'h8f, 8'h55};

    // 40 ns clock
    always #20 clk = ~clk;
    // Cycle count for measuring frame spacing
    always @(posedge clk) cycleCount <= cycleCount + 1;

    ufc_frame_timing i_dut (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid),
        .controllerResetCmd(controllerResetCmd), .operationalBusState(operationalBusState),
        .startOfFrameFlag(startOfFrameFlag), .largestPacketCount(largestPacketCount));

    // Stimulus register step
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected interval readback: reserved bits 15:14 always read zero
    function automatic logic [31:0] ivRead(input logic [31:0] w);
        return w & 32'hffff3fff;
    endfunction

    // Software side widening of the 16-bit frame number to 32 bits
    function automatic logic [31:0] extendCount(input logic [31:0] prev, input logic [15:0] hw);
        logic [15:0] upper;
        upper = prev[31:16];
        if (hw < prev[15:0]) upper = upper + 16'h0001;
        return {upper, hw};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("Compared %0d, mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One command; idle cycle after it so the strobe is never reassigned in one step
    task automatic cmd(input logic [7:0] code, input logic [31:0] data, output logic [31:0] ans);
        cmdValid = 1'b1;
        cmdCode = code;
        cmdWrData = data;
        @(posedge clk);
        #1;
        check({31'h0, rdValid}, 32'h1, "answer strobe");
        ans = rdData;
        cmdValid = 1'b0;
        @(posedge clk);
        #1;
        check(rdData | {31'h0, rdValid}, 32'h0, "answer released");
    endtask

    // Bounded wait for the next frame pulse; checks the largest-packet load there
    task automatic waitFlag(output int spacing);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (startOfFrameFlag === 1'b1) begin
                spacing = cycleCount - lastFlag;
                lastFlag = cycleCount;
                frames++;
                check({17'h0, largestPacketCount}, {17'h0, ivWord[30:16]}, "largest");
                return;
            end
        end
        $display("[FAIL] %0t frame pulse missing", $time);
        miscompares++;
        tally_and_finish();
    endtask

    // Main sequence
    initial begin
        int sp;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        cmd(8'h0d, 32'h0, rd);
        check(rd, 32'h00002edf, "interval reset");
        cmd(8'h0e, 32'h0, rd);
        check(rd, 32'h0, "remaining reset");
        cmd(8'h0f, 32'h0, rd);
        check(rd, 32'h0, "number reset");
        $display("Test reset values done");
        // Corners first, then random words; reserved bits 15:14 must drop out
        for (int i = 0; i < 10; i++) begin
            lfsrState = lfsrNext(lfsrState);
            ivWord[31:16] = lfsrState;
            lfsrState = lfsrNext(lfsrState);
            ivWord[15:0] = lfsrState;
            if (i == 0) ivWord = 32'hffffffff;
            if (i == 1) ivWord = 32'h0;
            cmd(8'h8d, ivWord, rd);
            check(rd, 32'h0, "write answer");
            ivWord = ivRead(ivWord);
            cmd(8'h0d, 32'h0, rd);
            check(rd, ivWord, "interval readback");
        end
        $display("Test interval access done");
        // Writes to read-only or unknown codes change nothing
        foreach (badCodes[k]) begin
            cmd(badCodes[k], 32'hffffffff, rd);
            check(rd, 32'h0, "refused write answer");
        end
        cmd(8'h0e, 32'h0, rd);
        check(rd, 32'h0, "remaining untouched");
        cmd(8'h0f, 32'h0, rd);
        check(rd, 32'h0, "number untouched");
        cmd(8'h0d, 32'h0, rd);
        check(rd, ivWord, "interval untouched");
        $display("Test refused writes done");
        // Reset command restores the interval field only
        savedWord = ivWord;
        controllerResetCmd = 1'b1;
        @(posedge clk);
        #1;
        controllerResetCmd = 1'b0;
        cmd(8'h0d, 32'h0, rd);
        ivWord = {ivWord[31:14], 14'h2edf};
        check(rd, ivWord, "interval after reset command");
        // Software puts its saved interval back, toggling the toggle bit
        savedWord[31] = ~savedWord[31];
        cmd(8'h8d, savedWord, rd);
        cmd(8'h0d, 32'h0, rd);
        check(rd, ivRead(savedWord), "interval restored");
        $display("Test reset command done");
        // Interval 11 gives 12 bit times, which is exactly 25 clocks
        ivWord = {1'b1, lfsrState[14:0], 16'd11};
        cmd(8'h8d, ivWord, rd);
        operationalBusState = 1'b1;
        waitFlag(sp);
        cmd(8'h0e, 32'h0, rd);
        check(rd, 32'h0000000b, "entry reload");
        cmd(8'h0f, 32'h0, rd);
        check(rd, 32'h1, "number after entry");
        for (int f = 0; f < 4; f++) begin
            waitFlag(sp);
            if (f > 0) check(32'(sp), 32'd25, "frame length");
            cmd(8'h0e, 32'h0, rd);
            check(rd, 32'h8000000b, "zero reload and toggle");
        end
        // Trim mid-frame: the running frame keeps its length, the next one changes
        ivWord = {1'b0, ivWord[30:16], 16'd23};
        cmd(8'h8d, ivWord, rd);
        waitFlag(sp);
        check(32'(sp), 32'd25, "running frame kept");
        cmd(8'h0e, 32'h0, rd);
        check(rd, 32'h00000017, "trimmed reload");
        waitFlag(sp);
        check(32'(sp), 32'd50, "trimmed frame length");
        cmd(8'h0f, 32'h0, rd);
        check(rd, 32'(frames), "number per pulse");
        swCount = extendCount(swCount, rd[15:0]);
        check(swCount, 32'(frames), "widened number");
        $display("Test frame timing done");
        // Counters stand still outside the operational state
        operationalBusState = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmd(8'h0e, 32'h0, held);
        repeat (40) @(posedge clk);
        #1;
        cmd(8'h0e, 32'h0, rd);
        check(rd, held, "remaining holds");
        operationalBusState = 1'b1;
        waitFlag(sp);
        cmd(8'h0e, 32'h0, rd);
        check(rd, 32'h00000017, "re-entry reload");
        cmd(8'h0f, 32'h0, rd);
        check(rd, 32'(frames), "number on re-entry");
        $display("Test operational hold done");
        tally_and_finish();
    end
endmodule // testbench
